/* File: bench/nvc_ctrl_monitor.sv */
// checker: port assertions of the save/load controller
module nvc_ctrl_monitor (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic status_sel_busy,
  input wire logic status_busy,
  input wire logic nvm_wr,
  input wire logic nvm_rd,
  input wire logic nvm_ack,
  input nvc_pkg::nvc_bank_wr_s bank_wr,
  input wire logic io_update,
  input wire logic soft_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_save_wait;
    nvm_wr && !nvm_ack;
  endsequence
  a_busy_route: assert property (status_busy |-> status_sel_busy) else $error("busy");
  a_one_dir: assert property (!(nvm_wr && nvm_rd)) else $error("dir");
  a_reset_pulse: assert property (soft_reset |=> !soft_reset) else $error("rst");
  a_reset_idle: assert property (soft_reset |-> !nvm_wr) else $error("rst wr");
  a_save_hold: assert property (s_save_wait |=> nvm_wr) else $error("wr");
  a_load_hold: assert property (nvm_rd && !nvm_ack |=> nvm_rd) else $error("rd");
  a_bank_load: assert property (bank_wr.wr |-> !nvm_wr && $past(nvm_rd) && $past(nvm_ack)) else $error("bank");
  a_update_pulse: assert property (io_update |=> !io_update) else $error("upd");
endmodule
bind nvc_ctrl nvc_ctrl_monitor u_mon (
  .clk_sys(clk_sys),
  .srst(srst),
  .status_sel_busy(status_sel_busy),
  .status_busy(status_busy),
  .nvm_wr(nvm_wr),
  .nvm_rd(nvm_rd),
  .nvm_ack(nvm_ack),
  .bank_wr(bank_wr),
  .io_update(io_update),
  .soft_reset(soft_reset)
);

/* File: bench/nvc_ctrl_test.sv */
// testbench: save, reload and refusal scenarios
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module nvc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, srst = 1'b1, load_sel_n = 1'b1, status_sel_busy = 1'b1, bad_mode = 1'b0;
  logic nvm_wr, nvm_rd, nvm_ack, nvm_bad, io_update, soft_reset, status_busy;
  logic [1:0] lat = 2'h0;
  logic [7:0] rdata, seg_addr, nvm_addr, nvm_wdata, nvm_rdata, seg_data, bank_rd_data, bw_data;
  logic [15:0] bank_rd_addr, bw_addr;
  // segment: one data byte at 0x1234, then update and end opcodes
  logic [7:0] seg_image [0:7] = '{8'h00, 8'h12, 8'h34, 8'h80, 8'hff, 8'hff, 8'hff, 8'hff};
  nvc_pkg::nvc_req_s req = '0;
  nvc_pkg::nvc_bank_wr_s bank_wr;
  int fail_count = 0, cmp_count = 0, cyc = 0, sr_cnt = 0, iu_cnt = 0, bw_cnt = 0;
  assign seg_data = seg_image[seg_addr[2:0]];
  assign bank_rd_data = bank_rd_addr == 16'h1234 ? 8'ha5 : 8'h00;
  nvc_ctrl #(.GAP_CYC(20)) uut (
    .clk_sys(clk_sys),
    .srst(srst),
    .req(req),
    .rdata(rdata),
    .load_sel_n(load_sel_n),
    .status_sel_busy(status_sel_busy),
    .status_busy(status_busy),
    .seg_addr(seg_addr),
    .seg_data(seg_data),
    .nvm_wr(nvm_wr),
    .nvm_rd(nvm_rd),
    .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata),
    .nvm_rdata(nvm_rdata),
    .nvm_ack(nvm_ack),
    .nvm_bad(nvm_bad),
    .bank_rd_addr(bank_rd_addr),
    .bank_rd_data(bank_rd_data),
    .bank_wr(bank_wr),
    .io_update(io_update),
    .soft_reset(soft_reset)
  );
  nvc_nvm_model mem (
    .clk_sys(clk_sys),
    .nvm_wr(nvm_wr),
    .nvm_rd(nvm_rd),
    .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata),
    .lat(lat),
    .bad_mode(bad_mode),
    .nvm_rdata(nvm_rdata),
    .nvm_ack(nvm_ack),
    .nvm_bad(nvm_bad)
  );
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    sr_cnt += soft_reset === 1'b1;
    iu_cnt += io_update === 1'b1;
    if (bank_wr.wr === 1'b1)
    begin
      bw_cnt++;
      bw_addr = bank_wr.addr;
      bw_data = bank_wr.data;
    end
    if (cyc == 3000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task report_and_stop();
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    req = '0;
    @(negedge clk_sys);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    req = '0;
    @(negedge clk_sys);
    `CHK(rdata, e)
  endtask
  task done();
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 200 && status_busy !== 1'b0; i++) @(negedge clk_sys);
    repeat (24) @(negedge clk_sys);
  endtask
  task t_locked();
    rd(12'hb01, 8'h00);
    rd(12'hb02, 8'h00);
    wr(12'hb03, 8'h01);
    rd(12'hb03, 8'h00);
  endtask
  task t_save();
    wr(12'hb02, 8'h01);
    lat = 2'h3;
    bad_mode = 1'b1;
    wr(12'hb03, 8'h01);
    `CHK(status_busy, 1'b1)
    status_sel_busy = 1'b0;
    @(negedge clk_sys);
    `CHK(status_busy, 1'b0)
    status_sel_busy = 1'b1;
    rd(12'hb03, 8'h01);
    done();
    `CHK(mem.store[3], 8'ha5)
    `CHK(mem.store[5], 8'hff)
    rd(12'hb03, 8'h00);
    rd(12'hb00, 8'h00);
    rd(12'hb01, 8'h01);
  endtask
  task t_reload();
    wr(12'hb02, 8'h03);
    @(negedge clk_sys);
    `CHK(sr_cnt, 0)
    load_sel_n = 1'b0;
    bad_mode = 1'b0;
    lat = 2'h0;
    wr(12'hb02, 8'h03);
    done();
    `CHK(sr_cnt, 1)
    `CHK(iu_cnt, 1)
    `CHK(bw_cnt, 1)
    `CHK(bw_addr, 16'h1234)
    `CHK(bw_data, 8'ha5)
    rd(12'hb01, 8'h00);
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    t_locked();
    t_save();
    t_reload();
    report_and_stop();
  end
endmodule

/* File: bench/nvc_nvm_model.sv */
// partner: store that answers each byte lat+1 cycles after it is asked for
module nvc_nvm_model (
  input wire logic clk_sys,
  input wire logic nvm_wr,
  input wire logic nvm_rd,
  input wire logic [7:0] nvm_addr,
  input wire logic [7:0] nvm_wdata,
  input wire logic [1:0] lat,
  input wire logic bad_mode,
  output logic [7:0] nvm_rdata,
  output logic nvm_ack,
  output logic nvm_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] store [0:7];
  logic [1:0] cnt = 2'h0;
  logic go;
  assign go = (nvm_wr | nvm_rd) & !nvm_ack;
  // data shows only with the acknowledge, junk otherwise
  assign nvm_rdata = nvm_ack ? store[nvm_addr[2:0]] : ~nvm_addr;
  assign nvm_bad = nvm_ack & bad_mode;
  always @(posedge clk_sys)
  begin
    nvm_ack <= go && cnt == lat;
    cnt <= go && cnt != lat ? cnt + 2'h1 : 2'h0;
    if (nvm_ack && nvm_wr)
      store[nvm_addr[2:0]] <= nvm_wdata;
  end
endmodule

/* File: hdl/nvc_ctrl.sv */
// nonvolatile save/load controller with its control and status registers
module nvc_ctrl #(
  parameter int GAP_CYC = nvc_pkg::XFER_GAP_CYC,
  parameter int SEG_AW = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input nvc_pkg::nvc_req_s req,
  output logic [7:0] rdata,
  input wire logic load_sel_n,
  input wire logic status_sel_busy,
  output logic status_busy,
  output logic [SEG_AW-1:0] seg_addr,
  input wire logic [7:0] seg_data,
  output logic nvm_wr,
  output logic nvm_rd,
  output logic [SEG_AW-1:0] nvm_addr,
  output logic [7:0] nvm_wdata,
  input wire logic [7:0] nvm_rdata,
  input wire logic nvm_ack,
  input wire logic nvm_bad,
  output logic [15:0] bank_rd_addr,
  input wire logic [7:0] bank_rd_data,
  output nvc_pkg::nvc_bank_wr_s bank_wr,
  output logic io_update,
  output logic soft_reset
);
  nvc_pkg::nvc_state_e state;
  nvc_pkg::nvc_state_e next_state;
  logic unlock;
  logic save_bit;
  logic busy;
  logic active;
  logic err;
  logic saving;
  logic pend;
  logic [SEG_AW-1:0] ptr;
  logic [SEG_AW-1:0] seg_ptr;
  logic [6:0] count;
  logic [15:0] addr;
  logic [15:0] gap_cnt;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  wire sel_status = hit(req.addr, nvc_pkg::ADDR_XFER_STATUS);
  wire sel_error = hit(req.addr, nvc_pkg::ADDR_DATA_ERROR);
  wire sel_ctl = hit(req.addr, nvc_pkg::ADDR_RELOAD_UNLOCK);
  wire sel_save = hit(req.addr, nvc_pkg::ADDR_SAVE_TRIGGER);
  wire wr_ctl = req.wr && sel_ctl;
  wire wr_save = req.wr && sel_save;
  // a trigger still waiting to start counts as busy, so a second one is refused
  wire start_save = wr_save && req.wdata[nvc_pkg::BIT_SAVE] && unlock && !busy;
  wire start_load = wr_ctl && req.wdata[nvc_pkg::BIT_RELOAD] && !load_sel_n && !busy;
  wire start_any = start_save || start_load;
  wire [7:0] cmd_byte = saving ? seg_data : nvm_rdata;
  wire cmd_is_op = cmd_byte[nvc_pkg::BIT_CMD_OPCODE];
  wire is_end = cmd_is_op && cmd_byte[6:0] == nvc_pkg::OP_END_OF_DATA;
  wire is_upd = cmd_is_op && cmd_byte[6:0] == nvc_pkg::OP_IO_UPDATE;
  wire step = active && nvm_ack;
  wire step_cmd = step && state == nvc_pkg::NVC_CMD;
  wire step_hi = step && state == nvc_pkg::NVC_ADDR_HI;
  wire step_lo = step && state == nvc_pkg::NVC_ADDR_LO;
  wire step_data = step && state == nvc_pkg::NVC_DATA;
  wire gap_done = gap_cnt == 16'(GAP_CYC - 1);
  wire done = step_cmd && is_end;

  assign active = state != nvc_pkg::NVC_IDLE && state != nvc_pkg::NVC_GAP;
  assign busy = active || pend;
  assign status_busy = status_sel_busy & busy;
  // segment index skips the data bytes, which come from the bank
  assign seg_addr = seg_ptr;
  assign nvm_addr = ptr;
  assign nvm_wr = active && saving && unlock;
  assign nvm_rd = active && !saving;
  assign nvm_wdata = state == nvc_pkg::NVC_DATA ? bank_rd_data : seg_data;
  assign bank_rd_addr = addr;

  always_comb
  begin
    next_rdata = nvc_pkg::RST_BYTE;
    if (sel_status)
      next_rdata[nvc_pkg::BIT_BUSY] = busy;
    else if (sel_error)
      next_rdata[nvc_pkg::BIT_ERROR] = err;
    else if (sel_ctl)
      next_rdata[nvc_pkg::BIT_UNLOCK] = unlock;
    else if (sel_save)
      next_rdata[nvc_pkg::BIT_SAVE] = save_bit;
  end

  always_comb
  begin
    next_state = state;
    case (state)
      nvc_pkg::NVC_IDLE:
        if (pend)
          next_state = nvc_pkg::NVC_CMD;
      nvc_pkg::NVC_CMD:
        if (step)
        begin
          if (is_end)
            next_state = nvc_pkg::NVC_GAP;
          else if (!cmd_is_op)
            next_state = nvc_pkg::NVC_ADDR_HI;
        end
      nvc_pkg::NVC_ADDR_HI:
        if (step)
          next_state = nvc_pkg::NVC_ADDR_LO;
      nvc_pkg::NVC_ADDR_LO:
        if (step)
          next_state = nvc_pkg::NVC_DATA;
      nvc_pkg::NVC_DATA:
        if (step && count == 7'h00)
          next_state = nvc_pkg::NVC_CMD;
      nvc_pkg::NVC_GAP:
        if (gap_done)
          next_state = nvc_pkg::NVC_IDLE;
      default:
        next_state = nvc_pkg::NVC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      state <= nvc_pkg::NVC_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      unlock <= 1'b0;
    else if (wr_ctl)
      unlock <= req.wdata[nvc_pkg::BIT_UNLOCK];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pend <= 1'b0;
      saving <= 1'b0;
    end
    else if (start_any)
    begin
      pend <= 1'b1;
      saving <= start_save;
    end
    else if (state == nvc_pkg::NVC_IDLE)
      pend <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      save_bit <= 1'b0;
    else if (start_any)
      save_bit <= start_save;
    else if (done)
      save_bit <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      err <= 1'b0;
    else if (start_any)
      err <= 1'b0;
    else if (active && nvm_ack && nvm_bad)
      err <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ptr <= '0;
      seg_ptr <= '0;
    end
    else if (start_any)
    begin
      ptr <= '0;
      seg_ptr <= '0;
    end
    else if (step)
    begin
      ptr <= ptr + 1'b1;
      if (state != nvc_pkg::NVC_DATA)
        seg_ptr <= seg_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      count <= '0;
      addr <= '0;
    end
    else if (step_cmd)
      count <= cmd_byte[6:0];
    else if (step_hi)
      addr[15:8] <= cmd_byte;
    else if (step_lo)
      addr[7:0] <= cmd_byte;
    else if (step_data)
    begin
      addr <= addr + 16'h0001;
      count <= count - 7'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      gap_cnt <= '0;
    else
      gap_cnt <= state == nvc_pkg::NVC_GAP ? gap_cnt + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      io_update <= 1'b0;
      soft_reset <= 1'b0;
      bank_wr <= '0;
    end
    else
    begin
      io_update <= step_cmd && is_upd && !saving;
      soft_reset <= start_load;
      bank_wr.wr <= step_data && !saving;
      bank_wr.addr <= addr;
      bank_wr.data <= nvm_rdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdata <= nvc_pkg::RST_BYTE;
    else if (req.rd)
      rdata <= next_rdata;
  end
endmodule

/* File: hdl/nvc_pkg.sv */
// package: register map, fields and timing for the nonvolatile save/load control
package nvc_pkg;
  localparam logic [11:0] ADDR_XFER_STATUS = 12'hb00;
  localparam logic [11:0] ADDR_DATA_ERROR = 12'hb01;
  localparam logic [11:0] ADDR_RELOAD_UNLOCK = 12'hb02;
  localparam logic [11:0] ADDR_SAVE_TRIGGER = 12'hb03;
  localparam int BIT_BUSY = 0;
  localparam int BIT_ERROR = 0;
  localparam int BIT_UNLOCK = 0;
  localparam int BIT_RELOAD = 1;
  localparam int BIT_SAVE = 0;
  localparam int BIT_CMD_OPCODE = 7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] OP_IO_UPDATE = 7'h00;
  localparam logic [6:0] OP_END_OF_DATA = 7'h7f;
  localparam int CLK_MHZ = 250;
  localparam int XFER_GAP_NS = 10000;
  localparam int XFER_GAP_CYC = (XFER_GAP_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    NVC_IDLE,
    NVC_CMD,
    NVC_ADDR_HI,
    NVC_ADDR_LO,
    NVC_DATA,
    NVC_GAP
  } nvc_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } nvc_req_s;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } nvc_bank_wr_s;
endpackage
